//--- pkg/pmc_pkg.sv
// Package for the transceiver misc control register bank.
// Assumes a single 100 MHz clock and a plain register port.
package pmc_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [5:0] OFS_MISC_CONFIG   = 6'h1E;
  localparam logic [5:0] OFS_SOFT_CONTROL  = 6'h1F;
  localparam logic [5:0] OFS_TEST_LANE     = 6'h25;
  localparam logic [5:0] OFS_XOVER_TIMER   = 6'h2C;
  localparam logic [5:0] OFS_INT_STATUS    = 6'h3A;
  localparam logic [5:0] OFS_INT_MASK      = 6'h3B;
  // Misc config fields
  localparam int BIT_FD_OVERRIDE = 11;
  localparam int BIT_ROBUST_XO   = 9;
  localparam int BIT_QUICK_XO    = 8;
  localparam int BIT_INT_OE      = 7;
  localparam int BIT_FORCE_INT   = 6;
  localparam int BIT_TEST_FAILED = 2;
  localparam int BIT_TEST_DONE   = 1;
  localparam int BIT_TEST_TRIG   = 0;
  // Soft control fields
  localparam int BIT_FULL_RESET  = 15;
  localparam int BIT_RESTART     = 14;
  // Test lane fields
  localparam int BIT_LANE_ALL    = 7;
  localparam int POS_LANE_SEL    = 5;
  localparam logic [7:0] TEST_LANE_HI_RST = 8'h04;
  // Crossover timer fields
  localparam int POS_XO_UPPER    = 4;
  localparam logic [11:0] XO_UPPER_RST   = 12'h141;
  localparam logic [3:0]  XO_TIMEOUT_RST = 4'hF;
  // Interrupt status bits
  localparam int INT_W            = 3;
  localparam int IBIT_TEST_DONE   = 0;
  localparam int IBIT_TEST_FAIL   = 1;
  localparam int IBIT_XO_TIMEOUT  = 2;
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_TIME_NS    = 1000000;
  localparam int MS_CYCLES       = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int XO_STEP_MS      = 32;
  localparam int MS_CNT_W        = 10;
endpackage

//--- core/pmc_regs.sv
// Misc control and status registers of an Ethernet transceiver.
// Assumes same-clock link status inputs and an external pad wire.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

//Function
// - With the override set, a forced 100BASE-TX partner and local autoneg or forced 100BASE-TX give full duplex.
// - With the override clear, duplex follows the standard resolution input.
// - Bit 9 enables robust crossover resolution, clear selects normal crossover.
// - Bit 8 enables quick crossover when both ends are forced 100BASE-TX.
// - Bit 7 makes the shared pad an interrupt output when 1, a power-down input when 0, reset 0.
// - Bit 6 holds the interrupt asserted regardless of events.
// - Config bits 5:3 and soft control bits 13:0 ignore writes and read zero.
// - Writing 1 to bit 0 starts the cable test; bit 1 reads 0 while it runs, 1 after, reset 1.
// - Bit 2 reads 1 after a failed cable test and 0 after a normal one.
// - Soft control bit 15 resets the device and all registers, then clears itself.
// - Soft control bit 14 resets the device keeping registers except cable test bits 2:1, which return to 0 and 1, then clears itself.
// - Test lane bit 7 drives the test mode on all 4 lanes.
// - With bit 7 clear, bits 6:5 pick lane A, B, C or D.
// - Timer codes 0, 1, 2 give 32, 64, 96 ms and the field resets to all ones.
module pmc_regs #(
  parameter int MS_CYCLES = pmc_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        local_autoneg,
  input  wire logic        local_forced_100tx,
  input  wire logic        partner_forced_100tx,
  input  wire logic        standard_full_duplex,
  output logic             full_duplex,
  output logic             robust_crossover_active,
  output logic             quick_crossover_active,
  input  wire logic        crossover_attempt_start,
  output logic             crossover_timeout,
  output logic             cable_test_trigger,
  input  wire logic        cable_test_end,
  input  wire logic        cable_test_fault,
  output logic             core_reset,
  output logic [3:0]       test_lane_enable,
  input  wire logic        interrupt_powerdown_pad_in,
  output logic             interrupt_powerdown_pad_out,
  output logic             interrupt_powerdown_pad_oe,
  output logic             power_down_request,
  output logic             irq
);
  logic        fd_override_reg;
  logic        robust_xo_reg;
  logic        quick_xo_reg;
  logic        int_oe_reg;
  logic        force_int_reg;
  logic        test_trig_reg;
  logic        test_done_reg;
  logic        test_failed_reg;
  logic        full_reset_reg;
  logic        restart_reg;
  logic [2:0]  lane_sel_reg;
  logic [11:0] xo_upper_reg;
  logic [3:0]  xo_timeout_reg;
  logic [2:0]  int_status_reg;
  logic [2:0]  int_status_next;
  logic [2:0]  int_mask_reg;
  logic [2:0]  int_event;
  logic        pad_meta_reg;
  logic        pad_sync_reg;
  logic [31:0] tick_cnt_reg;
  logic        ms_tick;
  logic [9:0]  ms_cnt_reg;
  logic        xo_run_reg;
  logic        wr_cfg;
  logic        wr_soft;
  logic        trig_write;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [9:0] xo_limit_ms(input logic [3:0] code);
    xo_limit_ms = 10'((32'(code) + 32'd1) * pmc_pkg::XO_STEP_MS);
  endfunction

  assign wr_cfg     = reg_wr && hit(reg_addr, pmc_pkg::OFS_MISC_CONFIG);
  assign wr_soft    = reg_wr && hit(reg_addr, pmc_pkg::OFS_SOFT_CONTROL);
  assign trig_write = wr_cfg && reg_wdata[pmc_pkg::BIT_TEST_TRIG];

  // Misc config register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fd_override_reg <= 1'b0;
      robust_xo_reg   <= 1'b0;
      quick_xo_reg    <= 1'b0;
      int_oe_reg      <= 1'b0;
      force_int_reg   <= 1'b0;
      test_trig_reg   <= 1'b0;
    end else if (full_reset_reg) begin
      fd_override_reg <= 1'b0;
      robust_xo_reg   <= 1'b0;
      quick_xo_reg    <= 1'b0;
      int_oe_reg      <= 1'b0;
      force_int_reg   <= 1'b0;
      test_trig_reg   <= 1'b0;
    end else if (wr_cfg) begin
      fd_override_reg <= reg_wdata[pmc_pkg::BIT_FD_OVERRIDE];
      robust_xo_reg   <= reg_wdata[pmc_pkg::BIT_ROBUST_XO];
      quick_xo_reg    <= reg_wdata[pmc_pkg::BIT_QUICK_XO];
      int_oe_reg      <= reg_wdata[pmc_pkg::BIT_INT_OE];
      force_int_reg   <= reg_wdata[pmc_pkg::BIT_FORCE_INT];
      test_trig_reg   <= reg_wdata[pmc_pkg::BIT_TEST_TRIG];
    end
  end

  // Cable test progress and result
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      test_done_reg      <= 1'b1;
      test_failed_reg    <= 1'b0;
      cable_test_trigger <= 1'b0;
    end else if (full_reset_reg || restart_reg) begin
      test_done_reg      <= 1'b1;
      test_failed_reg    <= 1'b0;
      cable_test_trigger <= 1'b0;
    end else begin
      cable_test_trigger <= trig_write;
      if (trig_write) begin
        test_done_reg   <= 1'b0;
        test_failed_reg <= 1'b0;
      end else if (cable_test_end && !test_done_reg) begin
        test_done_reg   <= 1'b1;
        test_failed_reg <= cable_test_fault;
      end
    end
  end

  // Self-clearing soft resets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_reset_reg <= 1'b0;
      restart_reg    <= 1'b0;
    end else begin
      full_reset_reg <= wr_soft && reg_wdata[pmc_pkg::BIT_FULL_RESET];
      restart_reg    <= wr_soft && reg_wdata[pmc_pkg::BIT_RESTART];
    end
  end

  assign core_reset = full_reset_reg || restart_reg;

  // Test lane and crossover timer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lane_sel_reg   <= 3'h0;
      xo_upper_reg   <= pmc_pkg::XO_UPPER_RST;
      xo_timeout_reg <= pmc_pkg::XO_TIMEOUT_RST;
    end else if (full_reset_reg) begin
      lane_sel_reg   <= 3'h0;
      xo_upper_reg   <= pmc_pkg::XO_UPPER_RST;
      xo_timeout_reg <= pmc_pkg::XO_TIMEOUT_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, pmc_pkg::OFS_TEST_LANE)) begin
        lane_sel_reg <= reg_wdata[pmc_pkg::BIT_LANE_ALL:pmc_pkg::POS_LANE_SEL];
      end
      if (hit(reg_addr, pmc_pkg::OFS_XOVER_TIMER)) begin
        xo_upper_reg   <= reg_wdata[15:pmc_pkg::POS_XO_UPPER];
        xo_timeout_reg <= reg_wdata[3:0];
      end
    end
  end

  // Lane enables from the selection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      test_lane_enable <= 4'h0;
    end else if (lane_sel_reg[2]) begin
      test_lane_enable <= 4'hF;
    end else begin
      test_lane_enable <= 4'(4'h1 << lane_sel_reg[1:0]);
    end
  end

  // Duplex resolution and crossover mode outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_duplex             <= 1'b0;
      robust_crossover_active <= 1'b0;
      quick_crossover_active  <= 1'b0;
    end else begin
      if (fd_override_reg && partner_forced_100tx &&
          (local_autoneg || local_forced_100tx)) begin
        full_duplex <= 1'b1;
      end else begin
        full_duplex <= standard_full_duplex;
      end
      robust_crossover_active <= robust_xo_reg;
      quick_crossover_active  <= quick_xo_reg && local_forced_100tx &&
                                 !local_autoneg && partner_forced_100tx;
    end
  end

  // Millisecond tick divider
  assign ms_tick = (tick_cnt_reg == 32'(MS_CYCLES - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= 32'h0;
    end else if (ms_tick || crossover_attempt_start) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  // Robust crossover timeout, runs only in robust mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xo_run_reg        <= 1'b0;
      ms_cnt_reg        <= 10'h000;
      crossover_timeout <= 1'b0;
    end else if (core_reset || !robust_xo_reg) begin
      xo_run_reg        <= 1'b0;
      ms_cnt_reg        <= 10'h000;
      crossover_timeout <= 1'b0;
    end else if (crossover_attempt_start) begin
      xo_run_reg        <= 1'b1;
      ms_cnt_reg        <= 10'h000;
      crossover_timeout <= 1'b0;
    end else begin
      crossover_timeout <= 1'b0;
      if (xo_run_reg && ms_tick) begin
        if (ms_cnt_reg + 10'h001 >= xo_limit_ms(xo_timeout_reg)) begin
          xo_run_reg        <= 1'b0;
          crossover_timeout <= 1'b1;
        end
        ms_cnt_reg <= ms_cnt_reg + 10'h001;
      end
    end
  end

  // Interrupt status, set wins over read-clear
  assign int_event[pmc_pkg::IBIT_TEST_DONE]  = cable_test_end && !test_done_reg;
  assign int_event[pmc_pkg::IBIT_TEST_FAIL]  = cable_test_end && !test_done_reg &&
                                               cable_test_fault;
  assign int_event[pmc_pkg::IBIT_XO_TIMEOUT] = crossover_timeout;
  always_comb begin
    int_status_next = int_status_reg;
    if (reg_rd && hit(reg_addr, pmc_pkg::OFS_INT_STATUS)) begin
      int_status_next = 3'h0;
    end
    int_status_next = int_status_next | int_event;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_status_reg <= 3'h0;
      int_mask_reg   <= pmc_pkg::INT_MASK_RST;
    end else if (full_reset_reg) begin
      int_status_reg <= 3'h0;
      int_mask_reg   <= pmc_pkg::INT_MASK_RST;
    end else begin
      int_status_reg <= int_status_next;
      if (reg_wr && hit(reg_addr, pmc_pkg::OFS_INT_MASK)) begin
        int_mask_reg <= reg_wdata[2:0];
      end
    end
  end

  // Interrupt line and shared pad
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq                        <= 1'b0;
      interrupt_powerdown_pad_oe <= 1'b0;
    end else begin
      irq <= force_int_reg || (|(int_status_reg & int_mask_reg));
      interrupt_powerdown_pad_oe <= int_oe_reg &&
        (force_int_reg || (|(int_status_reg & int_mask_reg)));
    end
  end
  assign interrupt_powerdown_pad_out = 1'b0;

  // Pad input synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pad_meta_reg <= 1'b1;
      pad_sync_reg <= 1'b1;
    end else begin
      pad_meta_reg <= interrupt_powerdown_pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end
  assign power_down_request = !int_oe_reg && !pad_sync_reg;

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      case (reg_addr)
        pmc_pkg::OFS_MISC_CONFIG: begin
          reg_rdata[pmc_pkg::BIT_FD_OVERRIDE] <= fd_override_reg;
          reg_rdata[pmc_pkg::BIT_ROBUST_XO]   <= robust_xo_reg;
          reg_rdata[pmc_pkg::BIT_QUICK_XO]    <= quick_xo_reg;
          reg_rdata[pmc_pkg::BIT_INT_OE]      <= int_oe_reg;
          reg_rdata[pmc_pkg::BIT_FORCE_INT]   <= force_int_reg;
          reg_rdata[pmc_pkg::BIT_TEST_FAILED] <= test_failed_reg;
          reg_rdata[pmc_pkg::BIT_TEST_DONE]   <= test_done_reg;
          reg_rdata[pmc_pkg::BIT_TEST_TRIG]   <= test_trig_reg;
        end
        pmc_pkg::OFS_SOFT_CONTROL: begin
          reg_rdata[pmc_pkg::BIT_FULL_RESET] <= full_reset_reg;
          reg_rdata[pmc_pkg::BIT_RESTART]    <= restart_reg;
        end
        pmc_pkg::OFS_TEST_LANE: begin
          reg_rdata <= {pmc_pkg::TEST_LANE_HI_RST, lane_sel_reg, 5'h00};
        end
        pmc_pkg::OFS_XOVER_TIMER: begin
          reg_rdata <= {xo_upper_reg, xo_timeout_reg};
        end
        pmc_pkg::OFS_INT_STATUS: begin
          reg_rdata[2:0] <= int_status_reg;
        end
        pmc_pkg::OFS_INT_MASK: begin
          reg_rdata[2:0] <= int_mask_reg;
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // Checks
  property p_fd_override;
    @(posedge clk) disable iff (sys_rst)
    fd_override_reg && partner_forced_100tx && local_autoneg
      |=> full_duplex;
  endproperty
  a_fd_override: assert property (p_fd_override)
    else $error("override did not force full duplex");

  property p_fd_standard;
    @(posedge clk) disable iff (sys_rst)
    !fd_override_reg |=> full_duplex == $past(standard_full_duplex);
  endproperty
  a_fd_standard: assert property (p_fd_standard)
    else $error("duplex differs from standard resolution");

  property p_force_irq;
    @(posedge clk) disable iff (sys_rst)
    force_int_reg |=> irq;
  endproperty
  a_force_irq: assert property (p_force_irq)
    else $error("forced interrupt not asserted");

  property p_pad_dir;
    @(posedge clk) disable iff (sys_rst)
    !int_oe_reg ##1 !int_oe_reg |-> !interrupt_powerdown_pad_oe;
  endproperty
  a_pad_dir: assert property (p_pad_dir)
    else $error("pad driven while in input mode");

  property p_rsvd_zero;
    @(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == pmc_pkg::OFS_SOFT_CONTROL
      |=> reg_rdata[13:0] == 14'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved soft control bits not zero");

  property p_test_running;
    @(posedge clk) disable iff (sys_rst)
    trig_write && !full_reset_reg && !restart_reg
      |=> !test_done_reg && cable_test_trigger;
  endproperty
  a_test_running: assert property (p_test_running)
    else $error("cable test did not start");

  property p_test_fail;
    @(posedge clk) disable iff (sys_rst)
    cable_test_end && !test_done_reg && !trig_write && !core_reset
      |=> test_done_reg && test_failed_reg == $past(cable_test_fault);
  endproperty
  a_test_fail: assert property (p_test_fail)
    else $error("cable test result not captured");

  property p_self_clear;
    @(posedge clk) disable iff (sys_rst)
    wr_soft && reg_wdata[pmc_pkg::BIT_FULL_RESET]
      |=> core_reset ##1 !robust_xo_reg && test_done_reg;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("full soft reset missing");

  property p_lanes_all;
    @(posedge clk) disable iff (sys_rst)
    lane_sel_reg[2] |=> test_lane_enable == 4'hF;
  endproperty
  a_lanes_all: assert property (p_lanes_all)
    else $error("lanes not all enabled");

  property p_lane_one;
    @(posedge clk) disable iff (sys_rst)
    !lane_sel_reg[2] |=> $onehot(test_lane_enable);
  endproperty
  a_lane_one: assert property (p_lane_one)
    else $error("single lane select not one-hot");

  c_test_fail: cover property (@(posedge clk) cable_test_end &&
                               cable_test_fault && !test_done_reg);
  c_timeout: cover property (@(posedge clk) crossover_timeout);
  c_soft_reset: cover property (@(posedge clk) full_reset_reg);
  c_irq: cover property (@(posedge clk) irq && !force_int_reg);
endmodule

//--- test/tb.sv
// Self-checking bench for the transceiver misc control register bank.
// Assumes pmc_pkg is compiled first and the bench drives every port.
`timescale 1ns/1ps
module tb;
  localparam int MSC = 10;
  logic        clk;
  logic        sys_rst;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        local_autoneg;
  logic        local_forced_100tx;
  logic        partner_forced_100tx;
  logic        standard_full_duplex;
  logic        full_duplex;
  logic        robust_crossover_active;
  logic        quick_crossover_active;
  logic        crossover_attempt_start;
  logic        crossover_timeout;
  logic        cable_test_trigger;
  logic        cable_test_end;
  logic        cable_test_fault;
  logic        core_reset;
  logic [3:0]  test_lane_enable;
  logic        pad_in;
  logic        pad_out;
  logic        pad_oe;
  logic        power_down_request;
  logic        irq;
  int          err_total;
  int          comparisons;
  logic [15:0] v;

  pmc_regs #(.MS_CYCLES(MSC)) DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .local_autoneg(local_autoneg),
    .local_forced_100tx(local_forced_100tx),
    .partner_forced_100tx(partner_forced_100tx),
    .standard_full_duplex(standard_full_duplex),
    .full_duplex(full_duplex),
    .robust_crossover_active(robust_crossover_active),
    .quick_crossover_active(quick_crossover_active),
    .crossover_attempt_start(crossover_attempt_start),
    .crossover_timeout(crossover_timeout),
    .cable_test_trigger(cable_test_trigger),
    .cable_test_end(cable_test_end), .cable_test_fault(cable_test_fault),
    .core_reset(core_reset), .test_lane_enable(test_lane_enable),
    .interrupt_powerdown_pad_in(pad_in),
    .interrupt_powerdown_pad_out(pad_out),
    .interrupt_powerdown_pad_oe(pad_oe),
    .power_down_request(power_down_request), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Waits for a design pulse; sel 0 trigger, 1 core reset
  task automatic wait_pulse(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      #1;
      if ((sel == 0) ? cable_test_trigger : core_reset) return;
      @(posedge clk);
    end
    err_total++;
    $display("BAD %0t pulse never seen", $time);
    summarize();
  endtask

  task automatic t_defaults();
    rd(6'h1E, v); chk(v, 16'h0002);
    rd(6'h1F, v); chk(v, 16'h0000);
    rd(6'h25, v); chk(v, 16'h0400);
    rd(6'h2C, v); chk(v, 16'h141F);
    chk({15'h0, pad_oe}, 16'h0000);
    wr(6'h00, 16'hFFFF);
    rd(6'h00, v); chk(v, 16'h0000);
  endtask

  task automatic t_config();
    wr(6'h1E, 16'h0FF8);
    rd(6'h1E, v); chk(v, 16'h0BC2);
    cyc(3);
    chk({15'h0, robust_crossover_active}, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    chk({14'h0, pad_oe, pad_out}, 16'h0002);
    @(posedge clk);
    local_autoneg <= 1'b1;
    partner_forced_100tx <= 1'b1;
    cyc(3);
    chk({15'h0, full_duplex}, 16'h0001);
    chk({15'h0, quick_crossover_active}, 16'h0000);
    @(posedge clk);
    local_autoneg <= 1'b0;
    local_forced_100tx <= 1'b1;
    cyc(3);
    chk({15'h0, full_duplex}, 16'h0001);
    chk({15'h0, quick_crossover_active}, 16'h0001);
    wr(6'h1E, 16'h0000);
    cyc(3);
    chk({15'h0, full_duplex}, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    chk({14'h0, robust_crossover_active, quick_crossover_active}, 16'h0);
    @(posedge clk);
    standard_full_duplex <= 1'b1;
    cyc(3);
    chk({15'h0, full_duplex}, 16'h0001);
  endtask

  task automatic t_cable(input logic fault);
    wr(6'h3B, 16'h0003);
    wr(6'h1E, 16'h0001);
    wait_pulse(0, 4);
    rd(6'h1E, v); chk(v & 16'h0006, 16'h0000);
    @(posedge clk);
    cable_test_end <= 1'b1;
    cable_test_fault <= fault;
    @(posedge clk);
    cable_test_end <= 1'b0;
    cable_test_fault <= 1'b0;
    cyc(3);
    chk({15'h0, irq}, 16'h0001);
    rd(6'h1E, v); chk(v & 16'h0006, {13'h0, fault, 2'b10});
    rd(6'h3A, v); chk(v, {14'h0, fault, 1'b1});
    cyc(3);
    chk({15'h0, irq}, 16'h0000);
  endtask

  task automatic t_lanes();
    int s;
    wr(6'h25, 16'h0080);
    cyc(3);
    chk({12'h0, test_lane_enable}, 16'h000F);
    for (s = 0; s < 4; s++) begin
      wr(6'h25, 16'(s << 5));
      rd(6'h25, v); chk(v, 16'h0400 | 16'(s << 5));
      cyc(2);
      chk({12'h0, test_lane_enable}, 16'(1 << s));
    end
  endtask

  task automatic t_timer(input int code, input logic en);
    int n;
    int exp_n;
    exp_n = (code + 1) * 32 * MSC;
    wr(6'h2C, 16'h1410 | 16'(code));
    wr(6'h3B, 16'h0004);
    wr(6'h1E, en ? 16'h0200 : 16'h0000);
    @(posedge clk);
    crossover_attempt_start <= 1'b1;
    @(posedge clk);
    crossover_attempt_start <= 1'b0;
    for (n = 1; n < exp_n + 40 && !crossover_timeout; n++) cyc(1);
    if (en) begin
      chk({15'h0, (n >= exp_n - 3 && n <= exp_n + 3)}, 16'h1);
      if (n >= exp_n + 40) summarize();
      rd(6'h3A, v); chk(v, 16'h0004);
    end else chk({15'h0, crossover_timeout}, 16'h0);
  endtask

  task automatic t_soft();
    wr(6'h25, 16'h0080);
    wr(6'h1F, 16'h7FFF);
    wait_pulse(1, 4);
    cyc(3);
    rd(6'h25, v); chk(v, 16'h0480);
    rd(6'h1F, v); chk(v, 16'h0000);
    wr(6'h2C, 16'h0003);
    wr(6'h1F, 16'h8000);
    wait_pulse(1, 4);
    cyc(3);
    rd(6'h25, v); chk(v, 16'h0400);
    rd(6'h2C, v); chk(v, 16'h141F);
    rd(6'h1F, v); chk(v, 16'h0000);
  endtask

  task automatic t_pad();
    @(posedge clk);
    pad_in <= 1'b0;
    cyc(5);
    chk({15'h0, power_down_request}, 16'h0001);
    wr(6'h1E, 16'h0080);
    cyc(3);
    chk({15'h0, power_down_request}, 16'h0000);
    @(posedge clk);
    pad_in <= 1'b1;
  endtask

  initial begin
    err_total = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    local_autoneg = 1'b0;
    local_forced_100tx = 1'b0;
    partner_forced_100tx = 1'b0;
    standard_full_duplex = 1'b0;
    crossover_attempt_start = 1'b0;
    cable_test_end = 1'b0;
    cable_test_fault = 1'b0;
    pad_in = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_defaults();
    t_config();
    t_cable(1'b1);
    t_cable(1'b0);
    t_lanes();
    for (int c = 0; c < 4; c++) t_timer(c, 1'b1);
    t_timer(15, 1'b1);
    t_timer(0, 1'b0);
    t_soft();
    t_pad();
    summarize();
  end
endmodule
